/* File: common/cpuif_defines.svh */
`ifndef CPUIF_DEFINES_SVH
`define CPUIF_DEFINES_SVH
`define CTL_OFFSET 16'h0000
`define DEACT_OFFSET 16'h1000
`define BIT_G1_IRQ_BLK 8
`define BIT_G1_FIQ_BLK 7
`define BIT_G0_IRQ_BLK 6
`define BIT_G0_FIQ_BLK 5
`define BIT_SHARED_BP 4
`define BIT_G0_FAST 3
`define BIT_G1_EN 1
`define BIT_G0_EN 0
`define BIT_NS_G1_EN 0
`define BIT_NS_G1_FIQ_BLK 5
`define BIT_NS_G1_IRQ_BLK 6
`define BIT_SPLIT_NS 10
`define BIT_SPLIT_S 9
`define ID_HI 23
`define ID_SPECIAL_LO 24'h0003FC
`define ID_SPECIAL_HI 24'h0003FF
`define BP_MAX 3'h7
`define BP_STEP 3'h1
`define CTL_RESET 32'h0000_0000
`endif

/* File: common/cpuif_pkg.sv */
package cpuif_pkg;
    typedef logic [31:0] word_type;
    typedef logic [23:0] interrupt_identifier_type;
    typedef enum logic [1:0] {
        ACC_SECURE = 2'b00,
        ACC_NONSECURE = 2'b01,
        ACC_NOSEC = 2'b10
    } access_type;
endpackage : cpuif_pkg

/* File: design/preempt_alias.sv */
`include "cpuif_defines.svh"
module preempt_alias (
    input wire logic [2:0] secure_point,
    input wire logic shared_sel,
    input wire logic two_states,
    output logic [2:0] ns_view
);
    // Saturating increment of the secure point when shared_sel and two_states are both set, else the secure point unchanged
    always_comb begin
        if (two_states && shared_sel) begin
            if (secure_point == `BP_MAX) begin
                ns_view = `BP_MAX;
            end else begin
                ns_view = secure_point + `BP_STEP;
            end
        end else begin
            ns_view = secure_point;
        end
    end
endmodule : preempt_alias

/* File: design/cpu_iface_ctrl_deactivate.sv */
`include "cpuif_defines.svh"
module cpu_iface_ctrl_deactivate #(
    parameter bit LEGACY_SUPPORT = 1'b1,
    parameter bit FORCE_G0_FAST = 1'b0
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire cpuif_pkg::word_type reg_wdata,
    input wire cpuif_pkg::access_type reg_access,
    output cpuif_pkg::word_type reg_rdata,
    input wire logic sre_el3_en,
    input wire logic el3_irq_path_block_ctl,
    input wire logic el3_fast_path_block_ctl,
    input wire logic sre_el1_en,
    input wire logic g0_pending,
    input wire logic g1_pending,
    input wire logic legacy_irq_in,
    input wire logic legacy_fiq_in,
    input wire logic [2:0] preempt_point_reg,
    input wire logic [2:0] alias_preempt_point_reg,
    input wire logic [2:0] bp_wdata,
    input wire logic bp_wr,
    output logic bp_wr_ok,
    output logic [2:0] bp_ns_view,
    output logic [2:0] g0_point,
    output logic [2:0] g1_point,
    output logic irq_out,
    output logic fiq_out,
    output logic deact_valid,
    output cpuif_pkg::interrupt_identifier_type deact_id,
    output logic deact_keep_prio
);
    import cpuif_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    logic rst_n;
    assign rst_n = rst_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Control fields
    logic g1_legacy_irq_path_block_q;
    logic g1_legacy_fast_path_block_q;
    logic g0_legacy_irq_path_block_q;
    logic g0_legacy_fast_path_block_q;
    logic shared_preempt_point_sel_q;
    logic g0_fast_route_sel_q;
    logic group_one_signal_en_q;
    logic group_zero_signal_en_q;
    logic secure_split_completion_mode_q;
    logic nonsecure_split_completion_mode_q;
    logic ctl_hit;
    logic deact_hit;
    logic ns_acc;
    logic irq_force;
    logic fiq_force;
    assign ctl_hit = (reg_addr == `CTL_OFFSET);
    assign deact_hit = (reg_addr == `DEACT_OFFSET);
    assign ns_acc = (reg_access == ACC_NONSECURE);
    assign irq_force = sre_el3_en && el3_irq_path_block_ctl;
    assign fiq_force = sre_el3_en && el3_fast_path_block_ctl;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            g1_legacy_irq_path_block_q <= 1'b0;
            g1_legacy_fast_path_block_q <= 1'b0;
            g0_legacy_irq_path_block_q <= 1'b0;
            g0_legacy_fast_path_block_q <= 1'b0;
            shared_preempt_point_sel_q <= 1'b0;
            g0_fast_route_sel_q <= 1'b0;
            group_one_signal_en_q <= 1'b0;
            group_zero_signal_en_q <= 1'b0;
            secure_split_completion_mode_q <= 1'b0;
            nonsecure_split_completion_mode_q <= 1'b0;
        end else if (reg_wr && ctl_hit) begin
            group_one_signal_en_q <= ns_acc ? reg_wdata[`BIT_NS_G1_EN]
                                            : reg_wdata[`BIT_G1_EN];
            if (ns_acc) begin
                nonsecure_split_completion_mode_q <= reg_wdata[`BIT_SPLIT_S];
            end else begin
                // Secure and no-security views share the split bit at 9
                g1_legacy_irq_path_block_q <= reg_wdata[`BIT_G1_IRQ_BLK];
                g1_legacy_fast_path_block_q <= reg_wdata[`BIT_G1_FIQ_BLK];
                g0_legacy_irq_path_block_q <= reg_wdata[`BIT_G0_IRQ_BLK];
                g0_legacy_fast_path_block_q <= reg_wdata[`BIT_G0_FIQ_BLK];
                shared_preempt_point_sel_q <= reg_wdata[`BIT_SHARED_BP];
                g0_fast_route_sel_q <= reg_wdata[`BIT_G0_FAST];
                group_zero_signal_en_q <= reg_wdata[`BIT_G0_EN];
                secure_split_completion_mode_q <= reg_wdata[`BIT_SPLIT_S];
                if (reg_access == ACC_SECURE) begin
                    nonsecure_split_completion_mode_q <=
                        reg_wdata[`BIT_SPLIT_NS];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective views
    logic eff_g1_irq_blk;
    logic eff_g1_fiq_blk;
    logic eff_g0_irq_blk;
    logic eff_g0_fiq_blk;
    logic eff_g0_fast;
    assign eff_g1_irq_blk = irq_force || !LEGACY_SUPPORT
        || g1_legacy_irq_path_block_q;
    assign eff_g0_irq_blk = irq_force || !LEGACY_SUPPORT
        || g0_legacy_irq_path_block_q;
    assign eff_g1_fiq_blk = fiq_force || !LEGACY_SUPPORT
        || g1_legacy_fast_path_block_q;
    assign eff_g0_fiq_blk = !LEGACY_SUPPORT
        || g0_legacy_fast_path_block_q;
    assign eff_g0_fast = FORCE_G0_FAST || g0_fast_route_sel_q;

    ////////////////////////////////////////////////////////////////////////
    // Readback
    always_comb begin
        reg_rdata = '0;
        if (reg_rd && ctl_hit) begin
            if (ns_acc) begin
                reg_rdata[`BIT_NS_G1_EN] = group_one_signal_en_q;
                reg_rdata[`BIT_SPLIT_S] = nonsecure_split_completion_mode_q;
                reg_rdata[`BIT_NS_G1_FIQ_BLK] = eff_g1_fiq_blk;
                reg_rdata[`BIT_NS_G1_IRQ_BLK] = eff_g1_irq_blk;
            end else begin
                reg_rdata[`BIT_G1_IRQ_BLK] = eff_g1_irq_blk;
                reg_rdata[`BIT_G1_FIQ_BLK] = eff_g1_fiq_blk;
                reg_rdata[`BIT_G0_IRQ_BLK] = eff_g0_irq_blk;
                reg_rdata[`BIT_G0_FIQ_BLK] = eff_g0_fiq_blk;
                reg_rdata[`BIT_SHARED_BP] = shared_preempt_point_sel_q;
                reg_rdata[`BIT_G0_FAST] = eff_g0_fast;
                reg_rdata[`BIT_G1_EN] = group_one_signal_en_q;
                reg_rdata[`BIT_G0_EN] = group_zero_signal_en_q;
                reg_rdata[`BIT_SPLIT_S] = secure_split_completion_mode_q;
                if (reg_access == ACC_SECURE) begin
                    reg_rdata[`BIT_SPLIT_NS] =
                        nonsecure_split_completion_mode_q;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Preemption point
    logic two_states;
    assign two_states = (reg_access != ACC_NOSEC);
    preempt_alias u_alias (
        .secure_point(preempt_point_reg),
        .shared_sel(shared_preempt_point_sel_q),
        .two_states(two_states),
        .ns_view(bp_ns_view)
    );
    assign g0_point = preempt_point_reg;
    assign g1_point = shared_preempt_point_sel_q ? preempt_point_reg
                                                 : alias_preempt_point_reg;
    assign bp_wr_ok = bp_wr && !(ns_acc && shared_preempt_point_sel_q);

    ////////////////////////////////////////////////////////////////////////
    // Signal routing
    logic g0_live;
    logic g1_live;
    logic irq_sig_on;
    logic fiq_sig_on;
    logic byp_irq;
    logic byp_fiq;
    assign g0_live = group_zero_signal_en_q && g0_pending;
    assign g1_live = group_one_signal_en_q && g1_pending;
    assign irq_sig_on = g1_live || (g0_live && !eff_g0_fast);
    assign fiq_sig_on = g0_live && eff_g0_fast;
    assign byp_irq = !sre_el1_en && legacy_irq_in
        && !(eff_g0_irq_blk && eff_g1_irq_blk);
    assign byp_fiq = !sre_el1_en && legacy_fiq_in
        && !(eff_g0_fiq_blk && eff_g1_fiq_blk);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out <= 1'b0;
            fiq_out <= 1'b0;
        end else begin
            irq_out <= irq_sig_on || (!irq_sig_on && byp_irq);
            fiq_out <= fiq_sig_on || (!fiq_sig_on && byp_fiq);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Deactivate
    logic split_on;
    always_comb begin
        case (reg_access)
            ACC_NONSECURE: split_on = nonsecure_split_completion_mode_q;
            ACC_SECURE: split_on = secure_split_completion_mode_q;
            ACC_NOSEC: split_on = secure_split_completion_mode_q;
            default: split_on = 1'b0;
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            deact_valid <= 1'b0;
            deact_id <= '0;
            deact_keep_prio <= 1'b0;
        end else begin
            deact_valid <= reg_wr && deact_hit && split_on;
            deact_keep_prio <= reg_wr && deact_hit && split_on;
            if (reg_wr && deact_hit && split_on) begin
                deact_id <= reg_wdata[`ID_HI:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence deact_req_s;
        reg_wr && deact_hit && split_on;
    endsequence
    sequence deact_pulse_s;
        deact_valid && deact_keep_prio;
    endsequence
    deact_gate_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (reg_wr && deact_hit && !split_on) |=> !deact_valid)
        else $error("deactivate taken with split mode off");
    deact_take_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        deact_req_s |=>
        (deact_valid && deact_id == $past(reg_wdata[`ID_HI:0])))
        else $error("deactivate lost");
    keep_prio_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        deact_req_s |=> deact_pulse_s)
        else $error("active priority hold missing");
    pulse_src_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        deact_valid |-> $past(reg_wr && deact_hit && split_on))
        else $error("deactivate without request");
    g1_route_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        g1_live |=> irq_out)
        else $error("group 1 not on irq");
    g1_not_fast_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (!eff_g0_fast && !byp_fiq) |=> !fiq_out)
        else $error("fiq raised without group 0 fast route");
    fast_route_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (g0_live && eff_g0_fast) |=> fiq_out)
        else $error("group 0 not on fiq");
    byp_block_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (!irq_sig_on && eff_g0_irq_blk && eff_g1_irq_blk) |=> !irq_out)
        else $error("blocked bypass irq reached the core");
    el1_ignore_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (sre_el1_en && !irq_sig_on && !fiq_sig_on) |=> !irq_out && !fiq_out)
        else $error("bypass active under system register access");
    bp_drop_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (ns_acc && shared_preempt_point_sel_q) |-> !bp_wr_ok)
        else $error("nonsecure point write passed");
    bp_sat_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (two_states && shared_preempt_point_sel_q
        && preempt_point_reg == `BP_MAX) |-> bp_ns_view == `BP_MAX)
        else $error("nonsecure point view not saturated");
    irq_force_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (reg_rd && ctl_hit && irq_force && reg_access == ACC_SECURE)
        |-> reg_rdata[`BIT_G1_IRQ_BLK] && reg_rdata[`BIT_G0_IRQ_BLK])
        else $error("irq block bits not forced");
    fiq_force_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (reg_rd && ctl_hit && fiq_force && reg_access == ACC_SECURE)
        |-> reg_rdata[`BIT_G1_FIQ_BLK])
        else $error("group 1 fiq block bit not forced");
    shared_pt_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        shared_preempt_point_sel_q |-> g1_point == g0_point)
        else $error("shared point not used");
    reset_zero_a: assert property (
        @(posedge mclk)
        $rose(rst_n) |-> !group_zero_signal_en_q
        && !group_one_signal_en_q)
        else $error("enables not zero after reset");
    ctl_reset_a: assert property (
        @(posedge mclk)
        $rose(rst_n) |-> !g1_legacy_irq_path_block_q
        && !g1_legacy_fast_path_block_q && !g0_legacy_irq_path_block_q
        && !g0_legacy_fast_path_block_q && !g0_fast_route_sel_q)
        else $error("control fields not zero after reset");
endmodule : cpu_iface_ctrl_deactivate

/* File: verif/pe_model.sv */
module pe_model (
    input wire logic mclk,
    input wire logic irq_line,
    input wire logic fiq_line,
    output logic irq_seen,
    output logic fiq_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // Core samples both request lines once a cycle
    always_ff @(posedge mclk) begin
        irq_seen <= irq_line;
        fiq_seen <= fiq_line;
    end
endmodule : pe_model

/* File: verif/cpu_iface_ctrl_deactivate_test.sv */
`include "cpuif_defines.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
$display("Error %0t: got %0h exp %0h", $time, (a), (e)); end end
module cpu_iface_ctrl_deactivate_test;
    import cpuif_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    word_type reg_wdata = 32'h0000_0000;
    access_type reg_access = ACC_SECURE;
    word_type reg_rdata;
    logic sre_el3_en = 1'b0;
    logic irq_blk = 1'b0;
    logic fiq_blk = 1'b0;
    logic sre_el1_en = 1'b0;
    logic g0_pending = 1'b0;
    logic g1_pending = 1'b0;
    logic leg_irq = 1'b0;
    logic leg_fiq = 1'b0;
    logic [2:0] main_pt = 3'h3;
    logic [2:0] alias_pt = 3'h5;
    logic bp_wr = 1'b0;
    logic bp_wr_ok, irq_out, fiq_out, deact_valid, deact_keep_prio;
    logic irq_seen, fiq_seen;
    logic [2:0] bp_ns_view, g0_point, g1_point;
    interrupt_identifier_type deact_id;
    word_type d;
    int n_mismatch = 0;
    int num_checks = 0;
    always #5 mclk = ~mclk;
    cpu_iface_ctrl_deactivate dut_u (.mclk(mclk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_access(reg_access), .reg_rdata(reg_rdata),
        .sre_el3_en(sre_el3_en), .el3_irq_path_block_ctl(irq_blk),
        .el3_fast_path_block_ctl(fiq_blk), .sre_el1_en(sre_el1_en),
        .g0_pending(g0_pending), .g1_pending(g1_pending),
        .legacy_irq_in(leg_irq), .legacy_fiq_in(leg_fiq),
        .preempt_point_reg(main_pt), .alias_preempt_point_reg(alias_pt),
        .bp_wdata(3'h0), .bp_wr(bp_wr), .bp_wr_ok(bp_wr_ok),
        .bp_ns_view(bp_ns_view), .g0_point(g0_point), .g1_point(g1_point),
        .irq_out(irq_out), .fiq_out(fiq_out), .deact_valid(deact_valid),
        .deact_id(deact_id), .deact_keep_prio(deact_keep_prio));
    pe_model pe_u (.mclk(mclk), .irq_line(irq_out), .fiq_line(fiq_out),
        .irq_seen(irq_seen), .fiq_seen(fiq_seen));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [15:0] a, input word_type v,
                      input access_type c);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_access <= c;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input access_type c);
        @(posedge mclk);
        reg_addr <= a;
        reg_access <= c;
        reg_rd <= 1'b1;
        @(negedge mclk);
        d = reg_rdata;
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic ctl(input word_type v);
        wr(`CTL_OFFSET, v, ACC_SECURE);
        repeat (3) @(posedge mclk);
        #1;
    endtask : ctl
    task automatic dw(input interrupt_identifier_type id, input access_type c,
                      input logic ok);
        wr(`DEACT_OFFSET, {8'h00, id}, c);
        #1;
        `CHK(deact_valid, ok)
        `CHK(deact_keep_prio, ok)
        if (ok) begin
            `CHK(deact_id, id)
            @(posedge mclk);
            #1;
            `CHK(deact_valid, 1'b0)
        end
    endtask : dw
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`CTL_OFFSET, ACC_SECURE);
        `CHK(d, `CTL_RESET)
        rd(16'h0800, ACC_SECURE);
        `CHK(d, 32'h0000_0000)
        $display("reset test done");
    endtask : t_reset
    task automatic t_route;
        @(posedge mclk);
        g0_pending <= 1'b1;
        ctl(32'h0000_0009);
        `CHK({irq_seen, fiq_seen}, 2'h1)
        ctl(32'h0000_0001);
        `CHK({irq_seen, fiq_seen}, 2'h2)
        ctl(32'h0000_0008);
        `CHK({irq_seen, fiq_seen}, 2'h0)
        g0_pending <= 1'b0;
        g1_pending <= 1'b1;
        ctl(32'h0000_000B);
        `CHK({irq_seen, fiq_seen}, 2'h2)
        ctl(32'h0000_0009);
        `CHK({irq_seen, fiq_seen}, 2'h0)
        g1_pending <= 1'b0;
        $display("routing test done");
    endtask : t_route
    task automatic t_bypass;
        @(posedge mclk);
        leg_irq <= 1'b1;
        leg_fiq <= 1'b1;
        ctl(32'h0000_0000);
        `CHK({irq_seen, fiq_seen}, 2'h3)
        ctl(32'h0000_0140);
        `CHK({irq_seen, fiq_seen}, 2'h1)
        ctl(32'h0000_00A0);
        `CHK({irq_seen, fiq_seen}, 2'h2)
        sre_el1_en <= 1'b1;
        ctl(32'h0000_0000);
        `CHK({irq_seen, fiq_seen}, 2'h0)
        sre_el1_en <= 1'b0;
        sre_el3_en <= 1'b1;
        irq_blk <= 1'b1;
        fiq_blk <= 1'b1;
        ctl(32'h0000_0000);
        `CHK({irq_seen, fiq_seen}, 2'h1)
        rd(`CTL_OFFSET, ACC_SECURE);
        `CHK(d & 32'h0000_01E0, 32'h0000_01C0)
        rd(`CTL_OFFSET, ACC_NONSECURE);
        `CHK(d & 32'h0000_0060, 32'h0000_0060)
        sre_el3_en <= 1'b0;
        leg_irq <= 1'b0;
        leg_fiq <= 1'b0;
        $display("bypass test done");
    endtask : t_bypass
    task automatic t_point;
        ctl(32'h0000_0000);
        `CHK({g0_point, g1_point}, 6'h1D)
        reg_access <= ACC_NONSECURE;
        bp_wr <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK(bp_wr_ok, 1'b1)
        ctl(32'h0000_0010);
        reg_access <= ACC_NONSECURE;
        @(posedge mclk);
        #1;
        `CHK({g0_point, g1_point}, 6'h1B)
        `CHK(bp_ns_view, 3'h4)
        `CHK(bp_wr_ok, 1'b0)
        main_pt <= 3'h7;
        @(posedge mclk);
        #1;
        `CHK(bp_ns_view, `BP_MAX)
        reg_access <= ACC_SECURE;
        @(posedge mclk);
        #1;
        `CHK(bp_wr_ok, 1'b1)
        bp_wr <= 1'b0;
        $display("point test done");
    endtask : t_point
    task automatic t_deact;
        ctl(32'h0000_0200);
        dw(24'h001C05, ACC_SECURE, 1'b1);
        dw(24'h000021, ACC_NONSECURE, 1'b0);
        ctl(32'h0000_0400);
        dw(24'h000022, ACC_SECURE, 1'b0);
        dw(24'h000023, ACC_NONSECURE, 1'b1);
        ctl(32'h0000_0200);
        dw(24'h000024, ACC_NOSEC, 1'b1);
        wr(`CTL_OFFSET, 32'h0000_0201, ACC_NONSECURE);
        rd(`CTL_OFFSET, ACC_NONSECURE);
        `CHK(d, 32'h0000_0201)
        rd(`CTL_OFFSET, ACC_SECURE);
        `CHK(d, 32'h0000_0602)
        $display("deactivate test done");
    endtask : t_deact
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_route();
        t_bypass();
        t_point();
        t_deact();
        print_verdict();
    end
endmodule : cpu_iface_ctrl_deactivate_test
